/* File: osc_cfg_consts.svh */
`ifndef OSC_CFG_CONSTS_SVH
`define OSC_CFG_CONSTS_SVH

// register byte offsets on the bus
`define ADDR_TUNING 12'h000
`define ADDR_PLLCON 12'h004
`define ADDR_CLKSTAT 12'h008
`define ADDR_UNLOCK 12'h00c
// unlock key words, written back to back
`define UNLOCK_KEY1 32'haa99_6655
`define UNLOCK_KEY2 32'h5566_99aa
// field positions
`define TUN_MSB 5
`define ODIV_LSB 24
`define MULT_LSB 16
`define IDIV_LSB 8
`define ICLK_BIT 7
`define RANGE_LSB 0
`define COSC_LSB 0
`define LOCK_BIT 4
`define UNLOCKED_BIT 5
// current oscillator code for the system pll
`define COSC_SYSTEM_PLL 3'h1
`define TUN_RESET 6'h00

`endif

/* File: osc_cfg_pkg.sv */
package osc_cfg_pkg;
   typedef enum logic [1:0] {
      UL_IDLE = 2'b00,
      UL_KEY1 = 2'b01,
      UL_OPEN = 2'b10
   } unlock_state_t;
   typedef logic [31:0] word_t;
endpackage : osc_cfg_pkg

/* File: osc_tune_and_pll_config.sv */
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`include "osc_cfg_consts.svh"

// Operation
// - tuning register bits 31..6 read zero and ignore writes
// - six-bit signed tuning code offsets the fast rc oscillator, zero is centre
// - tuning and pll control writes only accepted after the unlock sequence
// - pll control bits 31..27, 23, 15..11, 6..3 read zero, ignore writes
// - output divider bits 26..24 read/write, loaded from config word at reset
// - multiplier bits 22..16 read/write, loaded from config word at reset
// - input divider bits 10..8 read/write, loaded from config word at reset
// - bit 7 one selects fast rc, zero selects primary oscillator
// - input source bit loaded from config word at reset
// - range bits 2..0 read/write, loaded from config word at reset
// - pll control writes blocked while current oscillator code is 001
// - read-only current oscillator field reports 001 when pll is in use
// - clock select lock blocks configuration writes, cleared only by reset
module osc_tune_and_pll_config
   import osc_cfg_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // second config word defaults, stable around reset release
   input wire logic [2:0] cfgOutputDividerDefault,
   input wire logic [6:0] cfgMultiplierDefault,
   input wire logic [2:0] cfgInputDividerDefault,
   input wire logic cfgInputSourceDefault,
   input wire logic [2:0] cfgRangeDefault,
   // clock system status
   input wire logic [2:0] currentOscSelect,
   input wire logic clockSelectLock,
   // outputs to oscillator and pll
   output logic [5:0] tuningCode,
   output logic [2:0] pllOutputDivider,
   output logic [6:0] pllMultiplier,
   output logic [2:0] pllInputDivider,
   output logic pllInputSourceSelect,
   output logic [2:0] pllRangeSelect
);
   import osc_cfg_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // bus decode
   write_gate_if wg ();
   logic wrEn;
   logic pllActive;
   logic tunWrOk;
   logic pllWrOk;
   logic loadDefaults_reg;
   logic mapped;
   logic lockSticky_reg;
   logic clockLocked;

   function automatic logic isMapped(input logic [11:0] a);
      isMapped = (a == `ADDR_TUNING) || (a == `ADDR_PLLCON) ||
                 (a == `ADDR_CLKSTAT) || (a == `ADDR_UNLOCK);
   endfunction : isMapped

   // the two registers that need the unlock
   function automatic logic isProtected(input logic [11:0] a);
      isProtected = (a == `ADDR_TUNING) || (a == `ADDR_PLLCON);
   endfunction : isProtected

   assign pready = 1'b1; // zero wait states
   assign wrEn = psel && penable && pwrite;
   assign mapped = isMapped(paddr);
   assign pslverr = psel && penable && !mapped;
   assign pllActive = (currentOscSelect == `COSC_SYSTEM_PLL);
   // the raw input blocks at once, the sticky copy keeps blocking until reset
   assign clockLocked = lockSticky_reg || clockSelectLock;
   assign tunWrOk = wg.unlocked && !clockLocked;
   assign pllWrOk = tunWrOk && !pllActive;

   assign wg.wrStrobe = wrEn;
   assign wg.wrAddr = paddr;
   assign wg.wrData = pwdata;
   // any protected write, accepted or not, uses up the unlock
   assign wg.consume = wrEn && isProtected(paddr);

   unlock_seq u_unlock (
      .clk(clk),
      .rst(rst),
      .wg(wg)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // the lock is kept here too, so a lock input that falls again cannot reopen
   // the configuration; only a reset clears it
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         lockSticky_reg <= 1'b0;
      else if (clockSelectLock)
         lockSticky_reg <= 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // defaults are sampled by the clock after reset, never through the async path
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         loadDefaults_reg <= 1'b1;
      else
         loadDefaults_reg <= 1'b0;
   end

   // tuning code, reset to centre frequency
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         tuningCode <= `TUN_RESET;
      else if (wrEn && paddr == `ADDR_TUNING && tunWrOk)
         tuningCode <= pwdata[`TUN_MSB:0];
   end

   // pll fields: loaded from config word, then software; passed through undecoded
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pllOutputDivider <= 3'h0;
         pllMultiplier <= 7'h00;
         pllInputDivider <= 3'h0;
         pllInputSourceSelect <= 1'b0;
         pllRangeSelect <= 3'h0;
      end
      else if (loadDefaults_reg)
      begin
         pllOutputDivider <= cfgOutputDividerDefault;
         pllMultiplier <= cfgMultiplierDefault;
         pllInputDivider <= cfgInputDividerDefault;
         pllInputSourceSelect <= cfgInputSourceDefault;
         pllRangeSelect <= cfgRangeDefault;
      end
      else if (wrEn && paddr == `ADDR_PLLCON && pllWrOk)
      begin
         pllOutputDivider <= pwdata[`ODIV_LSB+:3];
         pllMultiplier <= pwdata[`MULT_LSB+:7];
         pllInputDivider <= pwdata[`IDIV_LSB+:3];
         pllInputSourceSelect <= pwdata[`ICLK_BIT];
         pllRangeSelect <= pwdata[`RANGE_LSB+:3];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read data, registered; unimplemented bits stay zero
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         prdata <= 32'h0000_0000;
      else if (psel && !penable && !pwrite)
      begin
         prdata <= 32'h0000_0000;
         unique case (paddr)
            `ADDR_TUNING: prdata[`TUN_MSB:0] <= tuningCode;
            `ADDR_PLLCON:
            begin
               prdata[`ODIV_LSB+:3] <= pllOutputDivider;
               prdata[`MULT_LSB+:7] <= pllMultiplier;
               prdata[`IDIV_LSB+:3] <= pllInputDivider;
               prdata[`ICLK_BIT] <= pllInputSourceSelect;
               prdata[`RANGE_LSB+:3] <= pllRangeSelect;
            end
            `ADDR_CLKSTAT:
            begin
               prdata[`COSC_LSB+:3] <= currentOscSelect;
               prdata[`LOCK_BIT] <= clockLocked;
               prdata[`UNLOCKED_BIT] <= wg.unlocked;
            end
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_pll_write;
      wrEn && paddr == `ADDR_PLLCON;
   endsequence

   // building blocks for the checks below
   sequence s_tun_write;
      wrEn && paddr == `ADDR_TUNING;
   endsequence

   sequence s_key1_write;
      wrEn && paddr == `ADDR_UNLOCK && pwdata == `UNLOCK_KEY1;
   endsequence

   sequence s_key2_write;
      wrEn && paddr == `ADDR_UNLOCK && pwdata == `UNLOCK_KEY2;
   endsequence

   sequence s_read_setup;
      psel && !penable && !pwrite;
   endsequence

   AST_LOCKED_TUN_HOLD: assert property (@(posedge clk) disable iff (rst)
      (wrEn && paddr == `ADDR_TUNING && !tunWrOk) |=> $stable(tuningCode))
      else $error("tuning changed without unlock");
   AST_PLL_ACTIVE_HOLD: assert property (@(posedge clk) disable iff (rst)
      (s_pll_write and (pllActive && !loadDefaults_reg)) |=> $stable(pllMultiplier) &&
      $stable(pllOutputDivider) && $stable(pllRangeSelect))
      else $error("pll fields changed while pll active");
   AST_LOCK_HOLD: assert property (@(posedge clk) disable iff (rst)
      (clockSelectLock && !loadDefaults_reg) |=> $stable(pllInputDivider))
      else $error("pll changed while clock lock set");
   AST_PLL_LOAD: assert property (@(posedge clk) disable iff (rst)
      (s_pll_write and (pllWrOk && !loadDefaults_reg)) |=>
      pllMultiplier == $past(pwdata[22:16]) && pllInputSourceSelect == $past(pwdata[7]))
      else $error("accepted pll write not stored");
   AST_TUN_READ_ZERO: assert property (@(posedge clk) disable iff (rst)
      (psel && !penable && !pwrite && paddr == `ADDR_TUNING) |=> prdata[31:6] == 26'h0)
      else $error("tuning upper bits not zero");
   AST_PLL_READ_ZERO: assert property (@(posedge clk) disable iff (rst)
      (psel && !penable && !pwrite && paddr == `ADDR_PLLCON) |=>
      prdata[31:27] == 5'h0 && !prdata[23] && prdata[15:11] == 5'h0 && prdata[6:3] == 4'h0)
      else $error("pll reserved bits not zero");
   AST_DEFAULTS: assert property (@(posedge clk) disable iff (rst)
      (loadDefaults_reg && !rst) |=> pllInputSourceSelect == $past(cfgInputSourceDefault) &&
      pllRangeSelect == $past(cfgRangeDefault) && pllOutputDivider == $past(cfgOutputDividerDefault))
      else $error("config defaults not loaded");
   AST_TUN_ONE_SHOT: assert property (@(posedge clk) disable iff (rst)
      (wrEn && paddr == `ADDR_TUNING) |=> !wg.unlocked)
      else $error("unlock survived a protected write");

   // the key pair opens the gate, anything else on the key register keeps it shut
   AST_UNLOCK_OPEN: assert property (@(posedge clk) disable iff (rst)
      (s_key1_write ##1 (!wrEn)[*3] ##1 s_key2_write) |=> wg.unlocked)
      else $error("key pair did not open the gate");

   AST_UNLOCK_CLOSE: assert property (@(posedge clk) disable iff (rst)
      (wrEn && paddr == `ADDR_UNLOCK && pwdata != `UNLOCK_KEY2) |=> !wg.unlocked)
      else $error("gate open after a wrong key");

   AST_PLL_ONE_SHOT: assert property (@(posedge clk) disable iff (rst)
      s_pll_write |=> !wg.unlocked)
      else $error("unlock survived a pll control write");

   // accepted writes land in full
   AST_TUN_LOAD: assert property (@(posedge clk) disable iff (rst)
      (s_tun_write and tunWrOk) |=> tuningCode == $past(pwdata[`TUN_MSB:0]))
      else $error("accepted tuning write not stored");

   AST_PLL_LOAD_REST: assert property (@(posedge clk) disable iff (rst)
      (s_pll_write and (pllWrOk && !loadDefaults_reg)) |=>
      pllOutputDivider == $past(pwdata[26:24]) && pllInputDivider == $past(pwdata[10:8]) &&
      pllRangeSelect == $past(pwdata[2:0]))
      else $error("pll divider or range not stored");

   // rejected writes and the lock leave every field alone
   AST_PLL_REJECT_HOLD: assert property (@(posedge clk) disable iff (rst)
      (s_pll_write and (!pllWrOk && !loadDefaults_reg)) |=> $stable(pllOutputDivider) &&
      $stable(pllMultiplier) && $stable(pllInputDivider) && $stable(pllInputSourceSelect) &&
      $stable(pllRangeSelect))
      else $error("rejected pll write changed a field");

   AST_PLL_ACTIVE_ICLK: assert property (@(posedge clk) disable iff (rst)
      (s_pll_write and (pllActive && !loadDefaults_reg)) |=> $stable(pllInputDivider) &&
      $stable(pllInputSourceSelect))
      else $error("pll input fields changed while pll active");

   AST_LOCK_TUN_HOLD: assert property (@(posedge clk) disable iff (rst)
      clockLocked |=> $stable(tuningCode))
      else $error("tuning changed while clock lock set");

   AST_LOCK_PLL_HOLD: assert property (@(posedge clk) disable iff (rst)
      (clockLocked && !loadDefaults_reg) |=> $stable(pllOutputDivider) &&
      $stable(pllMultiplier) && $stable(pllInputSourceSelect) && $stable(pllRangeSelect))
      else $error("pll fields changed while clock lock set");

   AST_LOCK_STICKY: assert property (@(posedge clk) disable iff (rst)
      lockSticky_reg |=> lockSticky_reg)
      else $error("clock lock cleared without reset");

   AST_DEFAULTS_REST: assert property (@(posedge clk) disable iff (rst)
      (loadDefaults_reg && !rst) |=> pllMultiplier == $past(cfgMultiplierDefault) &&
      pllInputDivider == $past(cfgInputDividerDefault))
      else $error("multiplier or input divider default not loaded");

   // read data mirror the fields as they stood at the setup edge
   AST_TUN_READ: assert property (@(posedge clk) disable iff (rst)
      (s_read_setup and (paddr == `ADDR_TUNING)) |=> prdata[`TUN_MSB:0] == $past(tuningCode))
      else $error("tuning read back wrong");

   AST_PLL_READ: assert property (@(posedge clk) disable iff (rst)
      (s_read_setup and (paddr == `ADDR_PLLCON)) |=>
      prdata[26:24] == $past(pllOutputDivider) && prdata[22:16] == $past(pllMultiplier) &&
      prdata[10:8] == $past(pllInputDivider) && prdata[7] == $past(pllInputSourceSelect) &&
      prdata[2:0] == $past(pllRangeSelect))
      else $error("pll control read back wrong");

   AST_STATUS_READ: assert property (@(posedge clk) disable iff (rst)
      (s_read_setup and (paddr == `ADDR_CLKSTAT)) |=> prdata[2:0] == $past(currentOscSelect) &&
      prdata[4] == $past(clockLocked) && prdata[31:6] == 26'h0 && !prdata[3])
      else $error("status read back wrong");
endmodule : osc_tune_and_pll_config

/* File: osc_tune_and_pll_config_test.sv */
`timescale 1ns/10ps
`include "osc_cfg_consts.svh"

module osc_tune_and_pll_config_test;
   import osc_cfg_pkg::*;
   ////////////////////////////////////////////////////////////////////////////////
   // stimulus signals given a value at time zero, observed signals left to the unit
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   word_t pwdata = 32'h0000_0000;
   word_t prdata;
   logic pready;
   logic pslverr;
   logic [2:0] cfgOutputDividerDefault = 3'h5;
   logic [6:0] cfgMultiplierDefault = 7'h2b;
   logic [2:0] cfgInputDividerDefault = 3'h3;
   logic cfgInputSourceDefault = 1'b1;
   logic [2:0] cfgRangeDefault = 3'h6;
   logic [2:0] currentOscSelect = 3'h2;
   logic clockSelectLock = 1'b0;
   logic [5:0] tuningCode;
   logic [2:0] pllOutputDivider;
   logic [6:0] pllMultiplier;
   logic [2:0] pllInputDivider;
   logic pllInputSourceSelect;
   logic [2:0] pllRangeSelect;
   int mismatches = 0;
   int compares = 0;

   osc_tune_and_pll_config uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cfgOutputDividerDefault(cfgOutputDividerDefault),
      .cfgMultiplierDefault(cfgMultiplierDefault), .cfgInputDividerDefault(cfgInputDividerDefault),
      .cfgInputSourceDefault(cfgInputSourceDefault), .cfgRangeDefault(cfgRangeDefault),
      .currentOscSelect(currentOscSelect), .clockSelectLock(clockSelectLock),
      .tuningCode(tuningCode), .pllOutputDivider(pllOutputDivider), .pllMultiplier(pllMultiplier),
      .pllInputDivider(pllInputDivider), .pllInputSourceSelect(pllInputSourceSelect),
      .pllRangeSelect(pllRangeSelect));

   // 200 MHz clock
   initial
   begin
      forever #2.5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // shared helpers
   task automatic report_and_stop;
      if (mismatches == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : report_and_stop

   task automatic check(input string what, input word_t seen, input word_t exp);
      compares++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // one apb transfer; request held until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [11:0] a, input word_t d, output word_t rd,
      output logic err);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (n >= 50)
      begin
         mismatches++;
         report_and_stop();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [11:0] a, input word_t d);
      word_t rd;
      logic err;
      apb(1'b1, a, d, rd, err);
      // the write lands at the access edge; let it settle before anyone looks
      @(posedge clk);
   endtask : wr

   task automatic rdchk(input string what, input logic [11:0] a, input word_t exp,
      input logic expErr);
      word_t rd;
      logic err;
      apb(1'b0, a, 32'h0000_0000, rd, err);
      check(what, rd, exp);
      check({what, " err"}, {31'h0, err}, {31'h0, expErr});
   endtask : rdchk

   // key pair that software owes before each protected write
   task automatic unlock;
      wr(`ADDR_UNLOCK, `UNLOCK_KEY1);
      wr(`ADDR_UNLOCK, `UNLOCK_KEY2);
   endtask : unlock

   function automatic word_t pllWord(input logic [2:0] od, input logic [6:0] m,
      input logic [2:0] id, input logic ic, input logic [2:0] r);
      return {5'h00, od, 1'b0, m, 5'h00, id, ic, 4'h0, r};
   endfunction : pllWord

   task automatic checkPll(input string what, input word_t exp);
      check(what, {5'h00, pllOutputDivider, 1'b0, pllMultiplier, 5'h00, pllInputDivider,
         pllInputSourceSelect, 4'h0, pllRangeSelect}, exp);
   endtask : checkPll
   ////////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset;
      checkPll("pll outputs", pllWord(3'h5, 7'h2b, 3'h3, 1'b1, 3'h6));
      rdchk("pll read", `ADDR_PLLCON, pllWord(3'h5, 7'h2b, 3'h3, 1'b1, 3'h6), 1'b0);
      rdchk("tuning read", `ADDR_TUNING, 32'h0000_0000, 1'b0);
   endtask : t_reset

   // without the key sequence both registers keep their values
   task automatic t_no_unlock;
      wr(`ADDR_UNLOCK, `UNLOCK_KEY2); // a lone second key must not open the gate
      wr(`ADDR_TUNING, 32'h0000_001f);
      wr(`ADDR_PLLCON, 32'h0000_0000);
      check("tuning", {26'h0, tuningCode}, 32'h0000_0000);
      rdchk("pll kept", `ADDR_PLLCON, pllWord(3'h5, 7'h2b, 3'h3, 1'b1, 3'h6), 1'b0);
   endtask : t_no_unlock

   // unlock is one-shot, so the second write without keys is dropped
   task automatic t_tuning;
      unlock();
      rdchk("status open", `ADDR_CLKSTAT, 32'h0000_0022, 1'b0);
      wr(`ADDR_TUNING, 32'hffff_ffe0);
      check("tuning min", {26'h0, tuningCode}, 32'h0000_0020);
      rdchk("tuning upper", `ADDR_TUNING, 32'h0000_0020, 1'b0);
      wr(`ADDR_TUNING, 32'h0000_001f);
      check("tuning one shot", {26'h0, tuningCode}, 32'h0000_0020);
      unlock();
      wr(`ADDR_TUNING, 32'h0000_001f);
      check("tuning max", {26'h0, tuningCode}, 32'h0000_001f);
   endtask : t_tuning

   task automatic t_pll;
      unlock();
      wr(`ADDR_PLLCON, 32'hffff_ffff);
      rdchk("pll ones", `ADDR_PLLCON, 32'h077f_0787, 1'b0);
      checkPll("pll ones out", 32'h077f_0787);
      unlock();
      wr(`ADDR_PLLCON, 32'h0000_0000);
      checkPll("pll zero out", 32'h0000_0000);
   endtask : t_pll

   // pll as active source blocks pll control but status still reports it
   task automatic t_pll_active;
      currentOscSelect <= 3'h1;
      rdchk("status pll", `ADDR_CLKSTAT, 32'h0000_0001, 1'b0);
      unlock();
      wr(`ADDR_PLLCON, 32'hffff_ffff);
      rdchk("pll blocked", `ADDR_PLLCON, 32'h0000_0000, 1'b0);
      currentOscSelect <= 3'h2;
   endtask : t_pll_active

   task automatic t_lock;
      clockSelectLock <= 1'b1;
      rdchk("status lock", `ADDR_CLKSTAT, 32'h0000_0012, 1'b0);
      unlock();
      wr(`ADDR_TUNING, 32'h0000_0005);
      unlock();
      wr(`ADDR_PLLCON, 32'hffff_ffff);
      check("tuning locked", {26'h0, tuningCode}, 32'h0000_001f);
      checkPll("pll locked", 32'h0000_0000);
      clockSelectLock <= 1'b0;
      rdchk("lock kept", `ADDR_CLKSTAT, 32'h0000_0012, 1'b0);
      unlock();
      wr(`ADDR_TUNING, 32'h0000_0003);
      check("tuning still locked", {26'h0, tuningCode}, 32'h0000_001f);
      rdchk("unmapped", 12'h010, 32'h0000_0000, 1'b1);
   endtask : t_lock

   // a second reset clears the lock and reloads the config word defaults
   task automatic t_rerst;
      rst <= 1'b1;
      cfgMultiplierDefault <= 7'h11;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      checkPll("pll reload", pllWord(3'h5, 7'h11, 3'h3, 1'b1, 3'h6));
      check("tuning reload", {26'h0, tuningCode}, 32'h0000_0000);
      rdchk("status cleared", `ADDR_CLKSTAT, 32'h0000_0002, 1'b0);
   endtask : t_rerst
   ////////////////////////////////////////////////////////////////////////////////
   // main sequence: reset held 16 cycles, first check two edges later, first request one edge after that
   initial
   begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      t_reset();
      t_no_unlock();
      t_tuning();
      t_pll();
      t_pll_active();
      t_lock();
      t_rerst();
      report_and_stop();
   end
endmodule : osc_tune_and_pll_config_test

/* File: unlock_seq.sv */
`timescale 1ns/10ps
`include "osc_cfg_consts.svh"

// tracks the two-word unlock sequence on the unlock register
module unlock_seq
   import osc_cfg_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // write stream
   write_gate_if.gate wg
);
   unlock_state_t state_reg;
   unlock_state_t state_next;

   ////////////////////////////////////////////////////////////////////////////////
   // any stray write to the key register breaks the sequence; unlock stays open
   // until one protected write consumes it, so a runaway loop cannot rewrite twice
   always_comb
   begin
      state_next = state_reg;
      if (wg.wrStrobe && wg.wrAddr == `ADDR_UNLOCK)
      begin
         if (wg.wrData == `UNLOCK_KEY1)
            state_next = UL_KEY1;
         else if (wg.wrData == `UNLOCK_KEY2 && state_reg == UL_KEY1)
            state_next = UL_OPEN;
         else
            state_next = UL_IDLE;
      end
      else if (wg.consume)
         state_next = UL_IDLE;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         state_reg <= UL_IDLE;
      else
         state_reg <= state_next;
   end

   assign wg.unlocked = (state_reg == UL_OPEN);
endmodule : unlock_seq

/* File: write_gate_if.sv */
`timescale 1ns/10ps
// carries a decoded write between the top and the unlock tracker
interface write_gate_if;
   logic wrStrobe;
   logic [11:0] wrAddr;
   logic [31:0] wrData;
   logic unlocked;
   logic consume;
   modport top (output wrStrobe, output wrAddr, output wrData, output consume, input unlocked);
   modport gate (input wrStrobe, input wrAddr, input wrData, input consume, output unlocked);
endinterface : write_gate_if
